/* hdl/dbp_port.v */
// Debug port: background debug serial interface or boundary-scan pins.
// Assumes core status, access and TAP signals run on clock_i; pins do not.
//
// Contract
// - Select high gives boundary-scan, low gives debug
// - Select reads low unless driven high
// - Background debug halts core, DMA and timers
// - While halted, accept memory/register/peripheral commands
// - Device returns responses on serial output line
// - Breakpoint low halts after current instruction
// - Status clock marks when status is sampled
// - Debug data shows breakpoints or captured values
// - Processor status reported continuously on four bits
// - Boundary-scan uses five control signals
`timescale 1ns/1ns
`include "dbp_defines.vh"

module dbp_port (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // Mode select pin
  input  wire        mode_select_i,
  // Shared debug pins
  input  wire        breakpoint_request_n_i,
  input  wire        debug_serial_clock_i,
  input  wire        debug_serial_in_i,
  output wire        debug_serial_out_o,
  input  wire        status_sample_clock_i,
  output wire        status_sample_clock_o,
  output wire        status_sample_clock_oe_o,
  // Status pins
  output reg  [3:0]  processor_status_out_o,
  output reg  [3:0]  debug_data_out_o,
  // Core status and trace
  input  wire [3:0]  core_status_i,
  input  wire [3:0]  core_breakpoint_request_n_status_i,
  input  wire [3:0]  core_capture_i,
  input  wire        capture_select_i,
  input  wire        core_instr_done_i,
  // Halt of the processor complex
  output wire        halt_core_o,
  output wire        halt_dma_o,
  output wire        halt_timers_o,
  output wire        jtag_mode_o,
  // Debug access to the core
  output reg         access_req_o,
  output reg         access_write_o,
  output reg  [1:0]  access_space_o,
  output reg  [11:0] access_addr_o,
  output reg  [15:0] access_wdata_o,
  input  wire [15:0] access_rdata_i,
  input  wire        access_ack_i,
  // Boundary-scan controller side
  output reg         tap_tck_rise_o,
  output reg         tap_tck_fall_o,
  output reg         tap_tms_o,
  output reg         tap_tdi_o,
  output reg         tap_trst_n_o,
  input  wire        tap_tdo_i
);

  // ****************************************
  // States of the command sequencer
  // ****************************************
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_WDATA  = 3'b010;
  localparam [2:0] ST_ACCESS = 3'b100;

  // ****************************************
  // Declarations
  // ****************************************
  wire [4:0]              pins_sync;
  wire                    sel_sync;
  wire                    breakpoint_request_n_tms_sync;
  wire                    sclk_trst_sync;
  wire                    sdin_tdi_sync;
  wire                    tck_sync;
  wire [`DBP_PKT_MSB:0]   rx_word;
  wire                    rx_valid;
  wire                    bdm_sdout;
  wire [1:0]              rx_op;

  reg  [1:0]              settle_reg;
  reg                     mode_valid_reg;
  reg                     jtag_mode_reg;
  reg                     halt_pend_reg;
  reg                     halted_reg;
  reg  [2:0]              state_reg;
  reg  [`DBP_PKT_MSB:0]   resp_reg;
  reg                     status_sample_clock_reg;
  reg                     tck_prev_reg;
  reg                     tdo_reg;

  // Build an answer packet from its status bit and data
  function [`DBP_PKT_MSB:0] answer;
    input        err;
    input [15:0] data;
    begin
      answer = {err, data};
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  dbp_sync #(
    .W (5)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({mode_select_i, breakpoint_request_n_i, debug_serial_clock_i,
               debug_serial_in_i, status_sample_clock_i}),
    .sync_o  (pins_sync)
  );

  assign sel_sync       = pins_sync[4];
  assign breakpoint_request_n_tms_sync  = pins_sync[3];
  assign sclk_trst_sync = pins_sync[2];
  assign sdin_tdi_sync  = pins_sync[1];
  assign tck_sync       = pins_sync[0];

  // ****************************************
  // Mode capture at reset release
  // ****************************************
  // Select is caught once after the synchroniser settles; later changes
  // are ignored, so a glitch on the pin cannot flip the port mid-session
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      settle_reg     <= 2'h0;
      mode_valid_reg <= 1'b0;
      jtag_mode_reg  <= 1'b0;
    end else if (!mode_valid_reg) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == `DBP_MODE_SETTLE) begin
        mode_valid_reg <= 1'b1;
        jtag_mode_reg  <= sel_sync;
      end
    end
  end

  assign jtag_mode_o = jtag_mode_reg;

  // ****************************************
  // Background debug serial engine
  // ****************************************
  dbp_shift u_shift (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .enable_i   (mode_valid_reg & ~jtag_mode_reg),
    .sclk_i     (sclk_trst_sync),
    .sdin_i     (sdin_tdi_sync),
    .sdout_o    (bdm_sdout),
    .tx_word_i  (resp_reg),
    .rx_word_o  (rx_word),
    .rx_valid_o (rx_valid)
  );

  assign rx_op = rx_word[`DBP_OP_MSB:`DBP_OP_LSB];

  // Shared output line: responses or test data out
  assign debug_serial_out_o = jtag_mode_reg ? tdo_reg : bdm_sdout;

  // ****************************************
  // Breakpoint and halt
  // ****************************************
  // A request is ignored while halted, so a go command that meets one still resumes the core
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      halt_pend_reg <= 1'b0;
      halted_reg    <= 1'b0;
    end else begin
      if (mode_valid_reg && !jtag_mode_reg && !breakpoint_request_n_tms_sync && !halted_reg) begin
        halt_pend_reg <= 1'b1;
      end
      if (halt_pend_reg && core_instr_done_i) begin
        halted_reg    <= 1'b1;
        halt_pend_reg <= 1'b0;
      end else if (rx_valid && state_reg == ST_IDLE && rx_op == `DBP_OP_GO
                   && !halt_pend_reg) begin
        halted_reg <= 1'b0;
      end
    end
  end

  // Whole complex stops together while halted
  assign halt_core_o   = halted_reg;
  assign halt_dma_o    = halted_reg;
  assign halt_timers_o = halted_reg;

  // ****************************************
  // Command sequencer
  // ****************************************
  // Answer of each packet goes out in the packet that follows it
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg      <= ST_IDLE;
      resp_reg       <= {1'b0, `DBP_ANS_OK};
      access_req_o   <= 1'b0;
      access_write_o <= 1'b0;
      access_space_o <= 2'h0;
      access_addr_o  <= 12'h000;
      access_wdata_o <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (rx_valid) begin
            if (rx_op == `DBP_OP_NOP || rx_op == `DBP_OP_GO) begin
              resp_reg <= answer(1'b0, `DBP_ANS_OK);
            end else if (!halted_reg) begin
              resp_reg <= answer(1'b1, `DBP_ANS_NOT_HALT);
            end else begin
              access_space_o <= rx_word[`DBP_SPACE_MSB:`DBP_SPACE_LSB];
              access_addr_o  <= rx_word[`DBP_ADDR_MSB:0];
              access_write_o <= (rx_op == `DBP_OP_WRITE);
              if (rx_op == `DBP_OP_WRITE) begin
                resp_reg  <= answer(1'b0, `DBP_ANS_OK);
                state_reg <= ST_WDATA;
              end else begin
                resp_reg     <= answer(1'b1, `DBP_ANS_BUSY);
                access_req_o <= 1'b1;
                state_reg    <= ST_ACCESS;
              end
            end
          end
        end
        ST_WDATA: begin
          if (rx_valid) begin
            access_wdata_o <= rx_word[15:0];
            access_req_o   <= 1'b1;
            resp_reg       <= answer(1'b1, `DBP_ANS_BUSY);
            state_reg      <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          // Packets during an access only repeat the busy answer
          if (access_ack_i) begin
            access_req_o <= 1'b0;
            state_reg    <= ST_IDLE;
            if (access_write_o) begin
              resp_reg <= answer(1'b0, `DBP_ANS_OK);
            end else begin
              resp_reg <= answer(1'b0, access_rdata_i);
            end
          end
        end
        default: begin
          state_reg    <= ST_IDLE;
          access_req_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Status sample clock and status pins
  // ****************************************
  // Half the core rate; pins change as it falls so its rise lands mid-bit
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_sample_clock_reg             <= 1'b0;
      processor_status_out_o <= `DBP_PST_RESET;
      debug_data_out_o       <= `DBP_DEBUG_DATA_OUT_RESET;
    end else begin
      status_sample_clock_reg <= ~status_sample_clock_reg;
      if (status_sample_clock_reg) begin
        processor_status_out_o <= halted_reg ? `DBP_PST_HALTED
                                             : core_status_i;
        debug_data_out_o       <= capture_select_i ? core_capture_i
                                                   : core_breakpoint_request_n_status_i;
      end
    end
  end

  // Pin is an input (test clock) in boundary-scan mode
  assign status_sample_clock_o    = status_sample_clock_reg;
  assign status_sample_clock_oe_o = ~jtag_mode_reg;

  // ****************************************
  // Boundary-scan pass-through
  // ****************************************
  // Test clock edges found by sampling; limits the test clock to well
  // under half of the core clock
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tck_prev_reg   <= 1'b0;
      tap_tck_rise_o <= 1'b0;
      tap_tck_fall_o <= 1'b0;
      tap_tms_o      <= 1'b1;
      tap_tdi_o      <= 1'b1;
      tap_trst_n_o   <= 1'b0;
      tdo_reg        <= 1'b0;
    end else begin
      tck_prev_reg   <= tck_sync;
      tap_tck_rise_o <= jtag_mode_reg & tck_sync & ~tck_prev_reg;
      tap_tck_fall_o <= jtag_mode_reg & ~tck_sync & tck_prev_reg;
      tap_tms_o      <= jtag_mode_reg ? breakpoint_request_n_tms_sync : 1'b1;
      tap_tdi_o      <= jtag_mode_reg ? sdin_tdi_sync : 1'b1;
      // Test logic held reset outside boundary-scan mode
      tap_trst_n_o   <= jtag_mode_reg & sclk_trst_sync;
      if (jtag_mode_reg && !tck_sync && tck_prev_reg) begin
        tdo_reg <= tap_tdo_i;
      end
    end
  end

endmodule // dbp_port

/* hdl/dbp_defines.vh */
// Constants for the debug port: packet layout, command codes, status codes.
// Assumes inclusion by bare name from the port top and its serial engine.
`ifndef DBP_DEFINES_VH
`define DBP_DEFINES_VH

// ****************************************
// Serial packet layout
// ****************************************
`define DBP_PKT_BITS      17
`define DBP_PKT_MSB       16
`define DBP_CNT_W         5
`define DBP_OP_MSB        15
`define DBP_OP_LSB        14
`define DBP_SPACE_MSB     13
`define DBP_SPACE_LSB     12
`define DBP_ADDR_MSB      11

// ****************************************
// Command codes in the opcode field
// ****************************************
`define DBP_OP_NOP        2'h0
`define DBP_OP_READ       2'h1
`define DBP_OP_WRITE      2'h2
`define DBP_OP_GO         2'h3

// ****************************************
// Answer codes; busy and not-halted carried with status bit set, OK with it clear
// ****************************************
`define DBP_ANS_OK        16'h0000
`define DBP_ANS_BUSY      16'h0001
`define DBP_ANS_NOT_HALT  16'h0002

// ****************************************
// Status output codes and reset values
// ****************************************
`define DBP_PST_HALTED    4'hF
`define DBP_PST_RESET     4'h0
`define DBP_DEBUG_DATA_OUT_RESET   4'h0
`define DBP_MODE_SETTLE   2'h3

`endif

/* hdl/dbp_sync.v */
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clock_i; outputs are safe to decode.
`timescale 1ns/1ns

module dbp_sync #(
  parameter W = 5
) (
  // Clock and reset
  input  wire         clock_i,
  input  wire         rst_i,
  // Levels
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // dbp_sync

/* hdl/dbp_shift.v */
// Serial packet engine of the background debug port.
// Assumes the serial clock and input are already synchronised to clock_i.
`timescale 1ns/1ns
`include "dbp_defines.vh"

module dbp_shift (
  // Clock and reset
  input  wire                     clock_i,
  input  wire                     rst_i,
  // Synchronised link levels
  input  wire                     enable_i,
  input  wire                     sclk_i,
  input  wire                     sdin_i,
  output wire                     sdout_o,
  // Packet side
  input  wire [`DBP_PKT_MSB:0]    tx_word_i,
  output reg  [`DBP_PKT_MSB:0]    rx_word_o,
  output reg                      rx_valid_o
);

  reg                     sclk_prev_reg;
  reg [`DBP_CNT_W-1:0]    count_reg;
  reg [`DBP_PKT_MSB:0]    rx_shift_reg;
  reg [`DBP_PKT_MSB:0]    tx_shift_reg;
  wire                    rise;
  wire                    fall;

  assign rise    = enable_i & sclk_i & ~sclk_prev_reg;
  assign fall    = enable_i & ~sclk_i & sclk_prev_reg;
  assign sdout_o = tx_shift_reg[`DBP_PKT_MSB];

  // Input bits taken on rising edges, output moved on falling edges
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_reg <= 1'b0;
      count_reg     <= {`DBP_CNT_W{1'b0}};
      rx_shift_reg  <= {`DBP_PKT_BITS{1'b0}};
      tx_shift_reg  <= {`DBP_PKT_BITS{1'b0}};
      rx_word_o     <= {`DBP_PKT_BITS{1'b0}};
      rx_valid_o    <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_i;
      rx_valid_o    <= 1'b0;
      if (!enable_i) begin
        count_reg <= {`DBP_CNT_W{1'b0}};
      end else if (rise) begin
        rx_shift_reg <= {rx_shift_reg[`DBP_PKT_MSB-1:0], sdin_i};
        if (count_reg == `DBP_PKT_BITS - 1) begin
          count_reg  <= {`DBP_CNT_W{1'b0}};
          rx_word_o  <= {rx_shift_reg[`DBP_PKT_MSB-1:0], sdin_i};
          rx_valid_o <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
      // Idle: keep the answer loaded so its first bit is ready early
      if (count_reg == {`DBP_CNT_W{1'b0}} && !rise) begin
        tx_shift_reg <= tx_word_i;
      end else if (fall) begin
        tx_shift_reg <= {tx_shift_reg[`DBP_PKT_MSB-1:0], 1'b0};
      end
    end
  end

endmodule // dbp_shift

/* sim/dbp_dbg_model.sv */
// Debugger and test controller model driving the shared debug pins.
// Assumes clk_i is the core clock; every pin changes just after its rise.
`timescale 1ns/1ns

module dbp_dbg_model (
  // Core clock and answer line
  input  wire clk_i,
  input  wire dso_i,
  // Pins towards the port
  output reg  breakpoint_request_n_n_o,
  output reg  sclk_o,
  output reg  sdi_o,
  output reg  tck_o
);
  // ****************************************
  // Idle levels
  // ****************************************
  // Link clock stands low outside packets, test reset held low
  initial begin
    breakpoint_request_n_n_o = 1'b1;
    sclk_o   = 1'b0;
    sdi_o    = 1'b0;
    tck_o    = 1'b0;
  end

  // Half of the 800 ns link period
  task half;
    begin
      repeat (4) @(posedge clk_i);
    end
  endtask

  // 17 bits MSB first; answer bit taken before each rise
  task packet(input [16:0] tx, output [16:0] rx);
    integer i;
    begin
      for (i = 16; i >= 0; i = i - 1) begin
        sdi_o <= tx[i];
        half;
        rx[i] = dso_i;
        sclk_o <= 1'b1;
        half;
        sclk_o <= 1'b0;
      end
      sdi_o <= ~tx[0]; // Released line must not keep the last bit
      half;
    end
  endtask

  // One test clock with mode and data bits, test reset released
  task tclk(input tms, input tdi);
    begin
      breakpoint_request_n_n_o <= tms;
      sdi_o    <= tdi;
      sclk_o   <= 1'b1;
      half;
      tck_o <= 1'b1;
      half;
      tck_o <= 1'b0;
    end
  endtask
endmodule // dbp_dbg_model

/* sim/dbp_port_monitor.sv */
// Checker of the debug port, watching its top-level ports only.
// Assumes one clock domain, clock_i, with rst_i active high.
`timescale 1ns/1ns

module dbp_port_monitor (
  input wire        clock_i,
  input wire        rst_i,
  input wire        status_sample_clock_o,
  input wire        status_sample_clock_oe_o,
  input wire [3:0]  processor_status_out_o,
  input wire [3:0]  debug_data_out_o,
  input wire [3:0]  core_status_i,
  input wire [3:0]  core_breakpoint_request_n_status_i,
  input wire [3:0]  core_capture_i,
  input wire        capture_select_i,
  input wire        core_instr_done_i,
  input wire        halt_core_o,
  input wire        halt_dma_o,
  input wire        halt_timers_o,
  input wire        jtag_mode_o,
  input wire        access_req_o,
  input wire        access_ack_i,
  input wire        access_write_o,
  input wire [1:0]  access_space_o,
  input wire [11:0] access_addr_o,
  input wire        tap_trst_n_o,
  input wire        tap_tck_rise_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_halt_all_three: assert property (halt_dma_o == halt_core_o &&
    halt_timers_o == halt_core_o) else $error("halt outputs disagree");
  a_halt_at_boundary: assert property ($rose(halt_core_o) |->
    $past(core_instr_done_i)) else $error("halt not at instruction end");
  a_pst_halted: assert property ($fell(status_sample_clock_o) &&
    $past(halt_core_o) |-> processor_status_out_o == 4'hF)
    else $error("halted status code wrong");
  a_pst_running: assert property ($fell(status_sample_clock_o) &&
    !$past(halt_core_o) |-> processor_status_out_o == $past(core_status_i))
    else $error("status output not following core");
  a_debug_data_out_source: assert property ($fell(status_sample_clock_o) |->
    debug_data_out_o == ($past(capture_select_i) ? $past(core_capture_i)
    : $past(core_breakpoint_request_n_status_i))) else $error("debug data source wrong");
  a_sample_clk_runs: assert property (!$past(rst_i) |->
    status_sample_clock_o != $past(status_sample_clock_o))
    else $error("sample clock stalled");
  a_oe_by_mode: assert property (jtag_mode_o |->
    !status_sample_clock_oe_o) else $error("sample clock driven in scan mode");
  a_req_holds: assert property (access_req_o && !access_ack_i |=>
    access_req_o && $stable(access_addr_o) && $stable(access_space_o) &&
    $stable(access_write_o)) else $error("access request not held");
  a_req_drops: assert property (access_req_o && access_ack_i |=>
    !access_req_o) else $error("request kept after ack");
  a_req_halted: assert property ($rose(access_req_o) |-> halt_core_o)
    else $error("access while running");
  a_scan_idle: assert property (!jtag_mode_o |-> !tap_trst_n_o &&
    !tap_tck_rise_o) else $error("test logic active in debug mode");
endmodule // dbp_port_monitor

bind dbp_port dbp_port_monitor u_mon (.clock_i, .rst_i, .status_sample_clock_o,
  .status_sample_clock_oe_o, .processor_status_out_o, .debug_data_out_o,
  .core_status_i, .core_breakpoint_request_n_status_i, .core_capture_i, .capture_select_i,
  .core_instr_done_i, .halt_core_o, .halt_dma_o, .halt_timers_o, .jtag_mode_o,
  .access_req_o, .access_ack_i, .access_write_o, .access_space_o,
  .access_addr_o, .tap_trst_n_o, .tap_tck_rise_o);

/* sim/testbench.sv */
// Self-checking bench of the debug port with a debugger model.
// Assumes the core clock of 100 ns and the link timing of the model.
`timescale 1ns/1ns
`include "dbp_defines.vh"

module testbench;
  reg         clock_i = 1'b0;
  reg         rst, msel, csel, cdone, ack, tdo;
  reg  [3:0]  cst, cbk, ccap;
  reg  [15:0] rdat, s_wd, w;
  reg  [11:0] s_ad, a;
  reg  [1:0]  s_sp, sp;
  reg         s_wr, tdo_prev, tdo_exp;
  reg  [16:0] rx;
  wire        bk, sck, sdi, tck, debug_serial_out, sso, soe, hc, hd, ht, jm, req, wr;
  wire        tr, tf, tms, tdi, trst;
  wire [3:0]  processor_status_out, dd;
  wire [1:0]  spo;
  wire [11:0] ad;
  wire [15:0] wd;
  integer     seed, failures, cmp_count, cycles, ntr, n0, k, ack_wait;

  always #50 clock_i = ~clock_i;

  dbp_port dut (.clock_i(clock_i), .rst_i(rst), .mode_select_i(msel),
    .breakpoint_request_n_i(bk), .debug_serial_clock_i(sck),
    .debug_serial_in_i(sdi), .debug_serial_out_o(debug_serial_out),
    .status_sample_clock_i(tck), .status_sample_clock_o(sso),
    .status_sample_clock_oe_o(soe), .processor_status_out_o(processor_status_out),
    .debug_data_out_o(dd), .core_status_i(cst), .core_breakpoint_request_n_status_i(cbk),
    .core_capture_i(ccap), .capture_select_i(csel), .core_instr_done_i(cdone),
    .halt_core_o(hc), .halt_dma_o(hd), .halt_timers_o(ht), .jtag_mode_o(jm),
    .access_req_o(req), .access_write_o(wr), .access_space_o(spo),
    .access_addr_o(ad), .access_wdata_o(wd), .access_rdata_i(rdat),
    .access_ack_i(ack), .tap_tck_rise_o(tr), .tap_tck_fall_o(tf),
    .tap_tms_o(tms), .tap_tdi_o(tdi), .tap_trst_n_o(trst), .tap_tdo_i(tdo));

  dbp_dbg_model dbg (.clk_i(clock_i), .dso_i(debug_serial_out), .breakpoint_request_n_n_o(bk),
    .sclk_o(sck), .sdi_o(sdi), .tck_o(tck));

  // ****************************************
  // Core side and counters
  // ****************************************
  // Random core status, slow enough to be sampled; ack after random wait
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (tr === 1'b1)
      ntr = ntr + 1;
    cdone <= $random(seed);
    // Value the port caught on the last test clock fall
    if (tf === 1'b1)
      tdo_exp = tdo_prev;
    tdo_prev = tdo;
    tdo   <= $random(seed);
    if (cycles % 8 == 0) begin
      cst  <= $random(seed);
      cbk  <= $random(seed);
      ccap <= $random(seed);
      csel <= $random(seed);
    end
    ack <= 1'b0;
    // Wait is random but capped, so a read answer is ready for the next packet
    ack_wait = (req === 1'b1) ? ack_wait + 1 : 0;
    if (req === 1'b1 && !ack && ($random(seed) % 2 == 0 || ack_wait > 3)) begin
      ack  <= 1'b1;
      rdat <= $random(seed);
      s_wr <= wr;
      s_ad <= ad;
      s_sp <= spo;
      s_wd <= wd;
    end
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  task chk_w(input [8*10-1:0] nm, input [16:0] e, input [16:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task chk_b(input [8*10-1:0] nm, input e, input g);
    begin
      chk_w(nm, {16'h0000, e}, {16'h0000, g});
    end
  endtask

  // Bounded wait for the halt flag to reach a level
  task wait_halt(input v);
    begin
      repeat (200) if (hc !== v) @(posedge clock_i);
    end
  endtask

  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h021467ec;
    {failures, cmp_count, cycles, ntr, ack_wait} = 0;
    {rst, msel, csel, cdone, ack, tdo, cst, cbk, ccap, rdat} = 34'h2_0000_0000;
    repeat (20) @(posedge clock_i);
    chk_b("oe_rst", 1'b1, soe);
    chk_b("trst_rst", 1'b0, trst);
    rst <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk_b("mode_bdm", 1'b0, jm);
    $display("reset test done");
    dbg.packet({1'b0, 2'h1, 14'h0000}, rx);
    dbg.packet(17'h0_0000, rx);
    chk_w("refused", {1'b1, `DBP_ANS_NOT_HALT}, rx);
    $display("refusal test done");
    dbg.breakpoint_request_n_n_o <= 1'b0;
    wait_halt(1'b1);
    dbg.breakpoint_request_n_n_o <= 1'b1;
    chk_b("halt_core", 1'b1, hc);
    chk_b("halt_dma", 1'b1, hd);
    chk_b("halt_timer", 1'b1, ht);
    repeat (6) @(posedge clock_i);
    chk_w("pst_halt", 17'h0_000F, {13'h0000, processor_status_out});
    $display("halt test done");
    // Read then write at random places, boundary address first
    for (k = 0; k < 4; k = k + 1) begin
      a  = (k == 0) ? 12'hFFF : $random(seed);
      sp = $random(seed);
      w  = $random(seed);
      dbg.packet({1'b0, 2'h1, sp, a}, rx);
      dbg.packet(17'h0_0000, rx);
      chk_w("read_data", {1'b0, rdat}, rx);
      chk_w("read_addr", {3'h0, sp, a}, {2'h0, s_wr, s_sp, s_ad});
      dbg.packet({1'b0, 2'h2, sp, a}, rx);
      chk_w("nop_answer", 17'h0_0000, rx);
      dbg.packet({1'b0, w}, rx);
      repeat (30) @(posedge clock_i);
      chk_w("write_addr", {3'h1, sp, a}, {2'h0, s_wr, s_sp, s_ad});
      chk_w("write_data", {1'b0, w}, {1'b0, s_wd});
    end
    $display("access test done");
    dbg.packet({1'b0, 2'h3, 14'h0000}, rx);
    wait_halt(1'b0);
    chk_b("go_resumes", 1'b0, hc);
    repeat (40) @(posedge clock_i);
    $display("go test done");
    rst  <= 1'b1;
    msel <= 1'b1;
    repeat (5) @(posedge clock_i);
    rst <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk_b("mode_scan", 1'b1, jm);
    chk_b("oe_scan", 1'b0, soe);
    n0 = ntr;
    for (k = 0; k < 4; k = k + 1) begin
      sp = $random(seed);
      dbg.tclk(sp[0], sp[1]);
      repeat (6) @(posedge clock_i);
      chk_b("tdo", tdo_exp, debug_serial_out);
      chk_b("tms", sp[0], tms);
      chk_b("tdi", sp[1], tdi);
      chk_b("trst_high", 1'b1, trst);
    end
    chk_w("tck_rises", 17'h0_0004, ntr - n0);
    $display("scan test done");
    print_verdict;
  end
endmodule // testbench
